// File: include/edac_ram_defs.svh
`ifndef EDAC_RAM_DEFS_SVH
`define EDAC_RAM_DEFS_SVH

// Memory geometry.
`define RAM_KBYTES 16
`define DATA_W 32
`define CB_W 7

// Configuration register offset on the peripheral port.
`define CFG_OFFSET 8'h00

// Configuration register field positions.
`define CFG_TCB_LSB 0
`define CFG_TCB_MSB 6
`define CFG_EN_BIT 7
`define CFG_RB_BIT 8
`define CFG_WB_BIT 9
`define CFG_SIZE_LSB 10
`define CFG_SIZE_MSB 12
`define CFG_CNT_LSB 13
`define CFG_CNT_MSB 14

// Reset values of the initialised fields, then CNT_MAX where the counter saturates.
`define CFG_EN_RST 1'b0
`define CFG_RB_RST 1'b0
`define CFG_WB_RST 1'b0
`define CFG_CNT_RST 2'h0
`define CNT_MAX 2'h3

// Weight of each data column in the check matrix.
`define COL_WEIGHT 3

`endif

// File: include/edac_ram_pkg.sv
`default_nettype none
package edac_ram_pkg;

   typedef enum logic [2:0]
   {
      S_IDLE,
      S_FETCH,
      S_CHECK,
      S_FINISH,
      S_ERR
   } state_t;

   // Result of checking one stored word.
   typedef struct packed
   {
      logic [31:0] data;
      logic [6:0] cb;
      logic single;
      logic multi;
   } dec_t;

   // One captured bus access.
   typedef struct packed
   {
      logic [31:0] addr;
      logic [3:0] lanes;
      logic write;
   } acc_t;

endpackage : edac_ram_pkg
`default_nettype wire

// File: rtl/edac_onchip_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "edac_ram_defs.svh"

module edac_onchip_ram
   import edac_ram_pkg::*;
#(
   parameter int KBYTES = `RAM_KBYTES
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // AHB slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic [1:0] o_hresp,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata
);

   localparam int DEPTH = KBYTES * 256;
   localparam int AW = $clog2(DEPTH);
   localparam logic [2:0] SIZE_CODE = 3'($clog2(KBYTES));

   // Storage: four byte lanes per word plus the check bits.
   logic [3:0][7:0] mem_d [DEPTH];
   logic [6:0] mem_c [DEPTH];

   state_t state_r;
   acc_t acc_r;
   logic en_acc_r;
   logic wr_pend_r;
   logic [31:0] rd_d_r;
   logic [6:0] rd_c_r;
   dec_t dec_r;
   logic [31:0] wdata_r;
   logic [31:0] hrdata_r;
   logic hready_r;
   logic [1:0] hresp_r;
   logic [31:0] prdata_r;

   // Configuration fields.
   logic en_r;
   logic rb_r;
   logic wb_r;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [6:0] tcb_r;

   logic accept;
   logic apb_wr;
   logic apb_rd;
   logic [3:0] acc_lanes;
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [3:0] mem_be;
   logic [31:0] mem_wd;
   logic mem_cb_we;
   logic [6:0] mem_wc;
   logic [31:0] merged;
   logic [31:0] cfg_val;

   // Data columns are the first 32 weight-three codes; weight-one
   // syndromes then point at check bits and even weights are doubles.
   function automatic logic [6:0] ecc_encode(input logic [31:0] d);
      logic [6:0] c;
      int n;
      c = '0;
      n = 0;
      for (int v = 0; v < 128; v++)
      begin
         if ($countones(7'(v)) == `COL_WEIGHT && n < 32)
         begin
            if (d[n])
            begin
               c = c ^ 7'(v);
            end
            n++;
         end
      end
      return c;
   endfunction : ecc_encode

   function automatic dec_t ecc_decode(input logic [31:0] d,
                                       input logic [6:0] c);
      dec_t r;
      logic [6:0] s;
      int n;
      r.data = d;
      r.cb = c;
      r.single = 1'b0;
      r.multi = 1'b0;
      s = c ^ ecc_encode(d);
      n = 0;
      if (s != '0)
      begin
         if ($countones(s) == 1)
         begin
            r.single = 1'b1;
         end
         else
         begin
            r.multi = 1'b1;
            for (int v = 0; v < 128; v++)
            begin
               if ($countones(7'(v)) == `COL_WEIGHT && n < 32)
               begin
                  if (7'(v) == s)
                  begin
                     r.data[n] = ~d[n];
                     r.single = 1'b1;
                     r.multi = 1'b0;
                  end
                  n++;
               end
            end
         end
      end
      return r;
   endfunction : ecc_decode

   // Byte lanes touched by an access; the system is big-endian, so
   // byte address zero lands in bits 31 to 24.
   function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                            input logic [1:0] a);
      logic [3:0] m;
      if (size == 3'h0)
      begin
         m = 4'h1 << (2'h3 - a);
      end
      else if (size == 3'h1)
      begin
         m = a[1] ? 4'h3 : 4'hC;
      end
      else
      begin
         m = 4'hF;
      end
      return m;
   endfunction : lane_mask

   assign accept = i_hsel && i_hready && i_htrans[1] && state_r == S_IDLE;
   assign acc_lanes = lane_mask(i_hsize, i_haddr[1:0]);
   assign apb_wr = i_psel && i_penable && i_pwrite &&
                   i_paddr == `CFG_OFFSET;
   assign apb_rd = i_psel && !i_penable && !i_pwrite;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         merged[i*8 +: 8] = acc_r.lanes[i] ? wdata_r[i*8 +: 8]
                                           : dec_r.data[i*8 +: 8];
      end
   end

   // Single write port: a plain store in its data phase, or the
   // write-back of a read-modify-write.
   always_comb
   begin
      mem_wa = acc_r.addr[AW+1:2];
      mem_we = 1'b0;
      mem_be = acc_r.lanes;
      mem_wd = i_hwdata;
      mem_cb_we = 1'b0;
      mem_wc = wb_r ? tcb_r : ecc_encode(i_hwdata);
      if (wr_pend_r)
      begin
         mem_we = 1'b1;
         mem_cb_we = en_acc_r;
      end
      else if (state_r == S_FINISH && acc_r.write && !dec_r.multi)
      begin
         mem_we = 1'b1;
         mem_be = 4'hF;
         mem_wd = merged;
         mem_cb_we = 1'b1;
         mem_wc = wb_r ? tcb_r : ecc_encode(merged);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (mem_we)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (mem_be[i])
            begin
               mem_d[mem_wa][i] <= mem_wd[i*8 +: 8];
            end
         end
         if (mem_cb_we)
         begin
            mem_c[mem_wa] <= mem_wc;
         end
      end
   end

   // Array read port, used one cycle after the address phase.
   always_ff @(posedge i_clk)
   begin
      if (state_r == S_FETCH)
      begin
         rd_d_r <= mem_d[acc_r.addr[AW+1:2]];
         rd_c_r <= mem_c[acc_r.addr[AW+1:2]];
      end
   end

   // Decode stage sits between the array and the bus.
   always_ff @(posedge i_clk)
   begin
      if (state_r == S_CHECK)
      begin
         dec_r <= ecc_decode(rd_d_r, rd_c_r);
      end
   end

   // Write data is stable while the slave stretches the data phase.
   always_ff @(posedge i_clk)
   begin
      if (state_r == S_FETCH)
      begin
         wdata_r <= i_hwdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc_r <= '0;
         en_acc_r <= 1'b0;
         wr_pend_r <= 1'b0;
      end
      else
      begin
         wr_pend_r <= 1'b0;
         if (accept)
         begin
            acc_r.addr <= i_haddr;
            acc_r.lanes <= acc_lanes;
            acc_r.write <= i_hwrite;
            en_acc_r <= en_r;
            // Word stores, and every store without protection, finish
            // in the data phase without waits.
            wr_pend_r <= i_hwrite && (acc_lanes == 4'hF || !en_r);
         end
      end
   end

   // Bus side sequencer.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r <= S_IDLE;
         hready_r <= 1'b1;
         hresp_r <= 2'h0;
         hrdata_r <= '0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               hresp_r <= 2'h0;
               hready_r <= 1'b1;
               if (accept && (!i_hwrite || (en_r && acc_lanes != 4'hF)))
               begin
                  state_r <= S_FETCH;
                  hready_r <= 1'b0;
               end
            end
            S_FETCH:
            begin
               state_r <= S_CHECK;
            end
            S_CHECK:
            begin
               if (en_acc_r)
               begin
                  state_r <= S_FINISH;
               end
               else
               begin
                  hrdata_r <= rd_d_r;
                  hready_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_FINISH:
            begin
               if (dec_r.multi)
               begin
                  hresp_r <= 2'h1;
                  state_r <= S_ERR;
               end
               else
               begin
                  hrdata_r <= dec_r.data;
                  hready_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_ERR:
            begin
               hready_r <= 1'b1;
               state_r <= S_IDLE;
            end
            default:
            begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // A corrected error in the same cycle as a clear still counts.
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (apb_wr)
      begin
         cnt_nxt = cnt_r & ~i_pwdata[`CFG_CNT_MSB:`CFG_CNT_LSB];
      end
      if (state_r == S_FINISH && dec_r.single && cnt_nxt != `CNT_MAX)
      begin
         cnt_nxt = cnt_nxt + 2'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         en_r <= `CFG_EN_RST;
         rb_r <= `CFG_RB_RST;
         wb_r <= `CFG_WB_RST;
         cnt_r <= `CFG_CNT_RST;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         if (apb_wr)
         begin
            en_r <= i_pwdata[`CFG_EN_BIT];
            rb_r <= i_pwdata[`CFG_RB_BIT];
            wb_r <= i_pwdata[`CFG_WB_BIT];
         end
      end
   end

   // Test check bits carry no reset; a capture beats a software write
   // so the fetched code is never lost.
   always_ff @(posedge i_clk)
   begin
      if (state_r == S_FINISH && rb_r)
      begin
         tcb_r <= dec_r.cb;
      end
      else if (apb_wr)
      begin
         tcb_r <= i_pwdata[`CFG_TCB_MSB:`CFG_TCB_LSB];
      end
   end

   always_comb
   begin
      cfg_val = '0;
      cfg_val[`CFG_TCB_MSB:`CFG_TCB_LSB] = tcb_r;
      cfg_val[`CFG_EN_BIT] = en_r;
      cfg_val[`CFG_RB_BIT] = rb_r;
      cfg_val[`CFG_WB_BIT] = wb_r;
      cfg_val[`CFG_SIZE_MSB:`CFG_SIZE_LSB] = SIZE_CODE;
      cfg_val[`CFG_CNT_MSB:`CFG_CNT_LSB] = cnt_r;
   end

   // Read data is latched in the setup phase; unmapped offsets read zero.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         prdata_r <= '0;
      end
      else if (apb_rd)
      begin
         prdata_r <= (i_paddr == `CFG_OFFSET) ? cfg_val : '0;
      end
   end

   assign o_hrdata = hrdata_r;
   assign o_hreadyout = hready_r;
   assign o_hresp = hresp_r;
   assign o_prdata = prdata_r;

endmodule : edac_onchip_ram
`default_nettype wire

// File: verification/edac_onchip_ram_sva.sv
`timescale 1ns/1ps
`default_nettype none
module edac_onchip_ram_sva
#(
   parameter int KBYTES = 16
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Memory port
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic [1:0] o_hresp,
   // Register port
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] o_prdata
);
   localparam logic [2:0] SZ = 3'($clog2(KBYTES));
   logic acc;
   logic setup;
   assign acc = i_hsel && i_hready && i_htrans[1] && o_hreadyout;
   assign setup = i_psel && !i_penable && !i_pwrite;
   default clocking dc @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   a_word_nowait: assert property (
      acc && i_hwrite && i_hsize == 3'h2 |=> o_hreadyout)
      else $error("word store stalled");
   a_read_wait: assert property (
      acc && !i_hwrite |=> !o_hreadyout [*2] ##[1:3] o_hreadyout)
      else $error("read wait count wrong");
   a_err_pair: assert property (
      o_hresp == 2'h1 && !o_hreadyout |=> o_hresp == 2'h1 && o_hreadyout)
      else $error("error response not two cycles");
   a_err_end: assert property (
      o_hresp == 2'h1 && o_hreadyout |=> o_hresp == 2'h0)
      else $error("error response too long");
   a_err_start: assert property (
      $rose(o_hresp[0]) |-> !o_hreadyout)
      else $error("error response started ready");
   a_idle_ready: assert property (
      o_hreadyout && !acc && o_hresp == 2'h0 |=> o_hreadyout)
      else $error("idle port stalled");
   a_resv_zero: assert property (
      o_prdata[31:15] == 17'h0)
      else $error("reserved bits set");
   a_size_code: assert property (
      $past(setup && i_paddr == 8'h00) |-> o_prdata[12:10] == SZ)
      else $error("size code wrong");
   a_unmapped: assert property (
      $past(setup && i_paddr != 8'h00) |-> o_prdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : edac_onchip_ram_sva
bind edac_onchip_ram edac_onchip_ram_sva #(.KBYTES(KBYTES))
   edac_onchip_ram_sva_inst (.*);
`default_nettype wire

// File: verification/edac_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module edac_bus_master
(
   // Clock
   input wire logic i_clk,
   // Memory port
   output logic i_hsel,
   output logic [31:0] i_haddr,
   output logic [1:0] i_htrans,
   output logic i_hwrite,
   output logic [2:0] i_hsize,
   output logic [31:0] i_hwdata,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic [1:0] o_hresp,
   // Register port
   output logic i_psel,
   output logic i_penable,
   output logic i_pwrite,
   output logic [7:0] i_paddr,
   output logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata
);
   initial
   begin
      {i_hsel, i_hwrite, i_psel, i_penable, i_pwrite} = 5'h0;
      {i_htrans, i_hsize, i_paddr} = 13'h0;
      {i_haddr, i_hwdata, i_pwdata} = 96'h0;
   end
   // Released data lines and the AHB address show the inverse of the last value, so a stale
   // value can never pass for a held one.
   task automatic ahb(input logic w, input logic [31:0] a,
      input logic [2:0] sz, input logic [31:0] d,
      output logic [31:0] q, output int n, output logic [1:0] r);
      @(posedge i_clk);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= a;
      i_hsize <= sz;
      @(posedge i_clk);
      while (!o_hreadyout) @(posedge i_clk);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_haddr <= ~a;
      i_hwdata <= d;
      n = 0;
      @(posedge i_clk);
      while (!o_hreadyout && n < 20)
      begin
         n++;
         @(posedge i_clk);
      end
      q = o_hrdata;
      r = o_hresp;
      i_hwdata <= ~d;
   endtask : ahb
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      q = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      i_pwdata <= ~d;
   endtask : apb
endmodule : edac_bus_master
`default_nettype wire

// File: verification/test_edac_onchip_ram.sv
`timescale 1ns/1ps
`default_nettype none
module test_edac_onchip_ram;
   logic i_clk, i_rstn, i_hsel, i_hwrite, i_hready, i_psel, i_penable;
   logic i_pwrite, o_hreadyout;
   logic [1:0] i_htrans, o_hresp, r;
   logic [2:0] i_hsize;
   logic [6:0] cb;
   logic [7:0] i_paddr;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, i_pwdata, o_prdata, q, cfg;
   int n, n_fail, comparisons;
   assign i_hready = o_hreadyout;
   edac_onchip_ram edac_onchip_ram_inst (.*);
   edac_bus_master edac_bus_master_inst (.*);
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rw(input logic w, input logic [31:0] a,
      input logic [2:0] sz, input logic [31:0] d);
      edac_bus_master_inst.ahb(w, a, sz, d, q, n, r);
   endtask : rw
   task automatic cf(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      edac_bus_master_inst.apb(w, a, d, cfg);
   endtask : cf
   task automatic rd(input logic [31:0] a, input logic [31:0] e,
      input int w);
      rw(1'b0, a, 3'h2, 32'h0);
      chk("rd data", e, q);
      chk("rd wait", 32'(w), 32'(n));
   endtask : rd
   task automatic final_report();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      final_report();
   end
   // Check bits are learned through capture, so no encoder is needed here.
   initial
   begin
      n_fail = 0;
      comparisons = 0;
      i_rstn = 1'b0;
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      cf(1'b0, 8'h00, 32'h0);
      chk("rst cfg", 32'h1000, cfg & 32'hFFFFFF80);
      cf(1'b1, 8'h00, 32'hFFFFFFFF);
      cf(1'b0, 8'h00, 32'h0);
      chk("cfg all", 32'h13FF, cfg);
      cf(1'b0, 8'h04, 32'h0);
      chk("unmapped", 32'h0, cfg);
      cf(1'b1, 8'h04, 32'h0);
      cf(1'b0, 8'h00, 32'h0);
      chk("unmapped wr", 32'h13FF, cfg);
      cf(1'b1, 8'h00, 32'h0);
      rw(1'b1, 32'h100, 3'h2, 32'h11223344);
      chk("wr32 wait", 32'h0, 32'(n));
      rw(1'b1, 32'h101, 3'h0, 32'h00AA0000);
      chk("wr8 wait", 32'h0, 32'(n));
      rd(32'h100, 32'h11AA3344, 2);
      cf(1'b1, 8'h00, 32'h80);
      rw(1'b1, 32'h200, 3'h2, 32'hCAFE0001);
      chk("wr32 wait", 32'h0, 32'(n));
      rw(1'b1, 32'h202, 3'h1, 32'h0000BEEF);
      chk("wr16 wait", 32'h3, 32'(n));
      rd(32'h200, 32'hCAFEBEEF, 3);
      rw(1'b0, 32'h203, 3'h0, 32'h0);
      chk("rd8 wait", 32'h3, 32'(n));
      chk("rd8 data", 32'hCAFEBEEF, q);
      cf(1'b1, 8'h00, 32'h180);
      rd(32'h200, 32'hCAFEBEEF, 3);
      cf(1'b0, 8'h00, 32'h0);
      cb = cfg[6:0];
      cf(1'b1, 8'h00, {25'h5, cb ^ 7'h01});
      rw(1'b1, 32'h200, 3'h2, 32'hCAFEBEEF);
      for (int i = 1; i < 5; i++)
      begin
         rd(32'h200, 32'hCAFEBEEF, 3);
         cf(1'b0, 8'h00, 32'h0);
         chk("count", 32'((i > 3) ? 3 : i), 32'(cfg[14:13]));
      end
      cf(1'b1, 8'h00, {25'h45, cb ^ 7'h01});
      cf(1'b0, 8'h00, 32'h0);
      chk("clear", 32'h2, 32'(cfg[14:13]));
      cf(1'b1, 8'h00, {25'h7, cb ^ 7'h03});
      rw(1'b1, 32'h200, 3'h2, 32'hCAFEBEEF);
      rw(1'b0, 32'h200, 3'h2, 32'h0);
      chk("rd resp", 32'h1, 32'(r));
      cf(1'b1, 8'h00, {25'h7, cb});
      rw(1'b1, 32'h201, 3'h0, 32'h0);
      chk("wr8 resp", 32'h1, 32'(r));
      cf(1'b0, 8'h00, 32'h0);
      chk("capture", {25'hA7, cb ^ 7'h03}, cfg);
      cf(1'b1, 8'h00, 32'h0);
      rd(32'h200, 32'hCAFEBEEF, 2);
      // A flipped data bit stored beside the clean word's code must be
      // corrected on a read and inside the merge of a subword store.
      cf(1'b1, 8'h00, {25'h5, cb});
      rw(1'b1, 32'h200, 3'h2, 32'hCAFEBEEE);
      rd(32'h200, 32'hCAFEBEEF, 3);
      cf(1'b0, 8'h00, 32'h0);
      chk("data fix", 32'h3, 32'(cfg[14:13]));
      cf(1'b1, 8'h00, 32'h00006080);
      rw(1'b1, 32'h200, 3'h1, 32'h12340000);
      rd(32'h200, 32'h1234BEEF, 3);
      cf(1'b0, 8'h00, 32'h0);
      chk("sub fix count", 32'h1, 32'(cfg[14:13]));
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      cf(1'b0, 8'h00, 32'h0);
      chk("mid rst cfg", 32'h1000, cfg & 32'hFFFFFF80);
      final_report();
   end
endmodule : test_edac_onchip_ram
`default_nettype wire
